// [gpio_port_pkg.sv]
package gpio_port_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam int REG_WIDTH = 8;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [3:0] DIR_OFFSET   = 4'h0;
  localparam logic [3:0] DATA_OFFSET  = 4'h4;
  localparam logic [3:0] STATE_OFFSET = 4'h8;
  localparam logic [3:0] ODSEL_OFFSET = 4'hC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] DIR_RESET   = 6'h00;
  localparam logic [5:0] DATA_RESET  = 6'h00;
  localparam logic [5:0] ODSEL_RESET = 6'h00;

  // Value returned for the write-only direction register
  localparam logic [31:0] DIR_READ_VALUE = 32'h00000000;

  // Bus request fields kept together
  typedef struct packed {
    logic [3:0] addr;
    logic       write;
    logic       lowLane;
    logic [5:0] data;
  } bus_req_t;

  // Alternate-function override for one pin
  typedef struct packed {
    logic sel;
    logic outEn;
    logic outVal;
  } alt_fn_t;

endpackage

// [pin_driver.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Single pin output stage
// ------------------------------------------------------------------
module pin_driver
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic dirOut,
  input  wire logic dataOut,
  input  wire logic openDrain,
  input  wire logic altSel,
  input  wire logic altOutEn,
  input  wire logic altOutVal,
  output logic      pinOut_q,
  output logic      pinOe_n_q
);

  logic wantDrive;
  logic driveVal;
  logic oeN_d;

  assign wantDrive = altSel ? altOutEn : dirOut;
  assign driveVal  = altSel ? altOutVal : dataOut;
  assign oeN_d = !(wantDrive && !(openDrain && driveVal));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinOut_q  <= 1'b0;
      pinOe_n_q <= 1'b1;
    end
    else
    begin
      pinOut_q  <= driveVal;
      pinOe_n_q <= oeN_d;
    end
  end

endmodule

// [six_pin_gpio_port.sv]
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
module six_pin_gpio_port
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         wb_err_o,
  input  wire logic [5:0]              pinIn,
  output logic      [5:0]              pinOut,
  output logic      [5:0]              pinOe_n,
  input  wire gpio_port_pkg::alt_fn_t [5:0] altFn
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [5:0]  dir_q;
  logic [5:0]  data_q;
  logic [5:0]  odSel_q;
  logic [5:0]  syncA_q;
  logic [5:0]  syncB_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] rdData_q;

  gpio_port_pkg::bus_req_t req;
  logic        reqNew;
  logic        hitDir;
  logic        hitData;
  logic        hitState;
  logic        hitOdSel;
  logic        hitAny;
  logic        wrLow;
  logic [5:0]  stateView;
  logic [31:0] rdData_d;

  // Bus request decode; ack drops the cycle after it was given
  assign req.addr    = wb_adr_i;
  assign req.write   = wb_we_i;
  assign req.lowLane = wb_sel_i[0];
  assign req.data    = wb_dat_i[5:0];
  assign reqNew   = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign hitDir   = req.addr == gpio_port_pkg::DIR_OFFSET;
  assign hitData  = req.addr == gpio_port_pkg::DATA_OFFSET;
  assign hitState = req.addr == gpio_port_pkg::STATE_OFFSET;
  assign hitOdSel = req.addr == gpio_port_pkg::ODSEL_OFFSET;
  assign hitAny   = hitDir || hitData || hitState || hitOdSel;
  assign wrLow    = reqNew && hitAny && req.write && req.lowLane;

  assign stateView = (dir_q & data_q) | (~dir_q & syncB_q);

  // Read mux; bits above the six pins always read zero
  // direction unreadable
  assign rdData_d =
    hitData  ? {26'h0000000, data_q}    :
    hitState ? {26'h0000000, stateView} :
    hitOdSel ? {26'h0000000, odSel_q}   :
    gpio_port_pkg::DIR_READ_VALUE;

  // ----------------------------------------------------------------
  // Bus answer, one wait state, unmapped gets err
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
      rdData_q <= 32'h00000000;
    end
    else
    begin
      ack_q    <= reqNew && hitAny;
      err_q    <= reqNew && !hitAny;
      rdData_q <= (reqNew && hitAny && !req.write) ? rdData_d : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdData_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // clear at reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dir_q   <= gpio_port_pkg::DIR_RESET;
      data_q  <= gpio_port_pkg::DATA_RESET;
      odSel_q <= gpio_port_pkg::ODSEL_RESET;
    end
    else
    begin
      if (wrLow && hitDir)
        dir_q <= req.data;
      if (wrLow && hitData)
        data_q <= req.data;
      if (wrLow && hitOdSel)
        odSel_q <= req.data;
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // two-stage sync; first stage feeds second only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
    end
    else
    begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, one per pin
  // ----------------------------------------------------------------
  // six pin stages
  for (genvar i = 0; i < gpio_port_pkg::PIN_COUNT; i++)
  begin : g_pin
    pin_driver u_drv
    (
      .core_clk  (core_clk),
      .rst       (rst),
      .dirOut    (dir_q[i]),
      .dataOut   (data_q[i]),
      .openDrain (odSel_q[i]),
      .altSel    (altFn[i].sel),
      .altOutEn  (altFn[i].outEn),
      .altOutVal (altFn[i].outVal),
      .pinOut_q  (pinOut[i]),
      .pinOe_n_q (pinOe_n[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wrDataS;
    wrLow && hitData;
  endsequence

  property dataWriteP;
    @(posedge core_clk) disable iff (rst)
    wrDataS |=> data_q == $past(req.data);
  endproperty

  data_write_a: assert property (dataWriteP)
    else $error("data register missed write");

  ack_once_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");

  state_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (reqNew && hitState && !req.write) |=>
      rdData_q == {26'h0000000, $past(stateView)})
    else $error("state read wrong");

  reserved_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wb_dat_o[31:6] == 26'h0000000)
    else $error("reserved bits not zero");

  state_nowrite_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (reqNew && hitState && req.write) |=>
      data_q == $past(data_q) && dir_q == $past(dir_q))
    else $error("state write changed state");

  od_release_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!altFn[0].sel && dir_q[0] && odSel_q[0] && data_q[0]) |=> pinOe_n[0])
    else $error("open drain drove high");

  pushpull_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!altFn[0].sel && dir_q[0] && !odSel_q[0]) |=>
      !pinOe_n[0] && pinOut[0] == $past(data_q[0]))
    else $error("push pull not driving");

  input_float_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!altFn[1].sel && !dir_q[1]) |=> pinOe_n[1])
    else $error("input pin driven");

  sync_path_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(rst) == 1'b0 |-> ##1 syncB_q == $past(pinIn, 2))
    else $error("sync path wrong");

  reset_clear_a: assert property (
    @(posedge core_clk)
    rst |=> dir_q == 6'h00 && data_q == 6'h00 && odSel_q == 6'h00)
    else $error("reset did not clear");

  // ----------------------------------------------------------------
  // Bus answer checks
  // ----------------------------------------------------------------
  sequence mappedS;
    reqNew && hitAny;
  endsequence

  sequence unmappedS;
    reqNew && !hitAny;
  endsequence

  sequence rdDataS;
    reqNew && hitData && !req.write;
  endsequence

  sequence rdDirS;
    reqNew && hitDir && !req.write;
  endsequence

  mapped_ack_a: assert property (
    @(posedge core_clk) disable iff (rst)
    mappedS |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");

  unmapped_err_a: assert property (
    @(posedge core_clk) disable iff (rst)
    unmappedS |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");

  err_once_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wb_err_o |=> !wb_err_o)
    else $error("err held two cycles");

  data_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rdDataS |=> wb_dat_o == {26'h0000000, $past(data_q)})
    else $error("data read wrong");

  dir_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rdDirS |=> wb_dat_o == gpio_port_pkg::DIR_READ_VALUE)
    else $error("direction read not fixed");

  // ----------------------------------------------------------------
  // Register write checks
  // ----------------------------------------------------------------
  sequence wrDirS;
    wrLow && hitDir;
  endsequence

  sequence wrOdSelS;
    wrLow && hitOdSel;
  endsequence

  sequence laneOffS;
    reqNew && req.write && !req.lowLane;
  endsequence

  dir_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wrDirS |=> dir_q == $past(req.data))
    else $error("direction register missed write");

  od_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wrOdSelS |=> odSel_q == $past(req.data))
    else $error("open-drain register missed write");

  lane_ignore_a: assert property (
    @(posedge core_clk) disable iff (rst)
    laneOffS |=> $stable(dir_q) && $stable(data_q) && $stable(odSel_q))
    else $error("write without low lane took effect");

  // ----------------------------------------------------------------
  // Pin stage checks
  // ----------------------------------------------------------------
  // Override must win even over an input direction bit
  alt_drive_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (altFn[0].sel && altFn[0].outEn && !odSel_q[0]) |=>
      !pinOe_n[0] && pinOut[0] == $past(altFn[0].outVal))
    else $error("alternate function not driving");

  reset_release_a: assert property (
    @(posedge core_clk) rst |=> pinOe_n == 6'h3F)
    else $error("pins driven after reset");

endmodule

// [board_pins.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board side of the six pins
// ----------------------------------------------------------------
module board_pins
(
  input  wire logic [5:0] pinOut,
  input  wire logic [5:0] pinOe_n,
  input  wire logic [5:0] extVal,
  input  wire logic [5:0] extEn,
  output logic      [5:0] pinIn
);
  // Pull-up wins when nobody drives, so a released drain reads high
  assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extEn & extVal)
               | (pinOe_n & ~extEn);
endmodule

// [test_six_pin_gpio_port.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench with register and pin model
// ----------------------------------------------------------------
module test_six_pin_gpio_port;
  logic                         core_clk, rst, cyc, stb, we, ack, err, e;
  logic [3:0]                   adr, sel;
  logic [31:0]                  wdat, rdat, seed, r;
  logic [5:0]                   pinIn, pinOut, pinOe_n, extVal, extEn;
  logic [5:0]                   mDir, mDat, mOd;
  gpio_port_pkg::alt_fn_t [5:0] altFn;
  int                           nErrors, checkCount;

  six_pin_gpio_port i_six_pin_gpio_port (.core_clk(core_clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .altFn(altFn));
  board_pins i_board_pins (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; holds everything until ack or err is sampled
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do @(posedge core_clk); while (ack !== 1'b1 && err !== 1'b1);
    r = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // pinOut does not matter on undriven pins (inputs and released drains), so mask it wherever pinOe_n is high
  task pins();
    logic [5:0] oe;
    logic [5:0] dv;
    for (int i = 0; i < 6; i++)
    begin
      dv[i] = altFn[i].sel ? altFn[i].outVal : mDat[i];
      oe[i] = !(altFn[i].sel ? altFn[i].outEn : mDir[i]) | (mOd[i] & dv[i]);
    end
    chk({26'h0, pinOe_n}, {26'h0, oe});
    chk({26'h0, pinOut & ~oe}, {26'h0, dv & ~oe});
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog, several times the seven hundred or so cycles needed
  initial
  begin
    #100000;
    nErrors++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'h867266EB;
    nErrors = 0;
    checkCount = 0;
    {rst, cyc, stb, we, adr, sel, wdat} = {3'h4, 41'h0};
    altFn = '0;
    extVal = 6'h00;
    extEn = 6'h3F;
    {mDir, mDat, mOd} = 18'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, gpio_port_pkg::DATA_OFFSET, 32'h0, 4'hF);
    chk(r, 32'h0);
    bus(1'b0, gpio_port_pkg::ODSEL_OFFSET, 32'h0, 4'hF);
    chk(r, 32'h0);
    pins();
    $display("test reset done");
    // Random settings, with upper bits set and ignored writes mixed in
    repeat (20)
    begin
      mDir = 6'(rnd());
      mDat = 6'(rnd());
      mOd = 6'(rnd());
      extVal <= 6'(rnd());
      extEn <= ~mDir;
      bus(1'b1, gpio_port_pkg::DIR_OFFSET, {26'h3FFFFFF, mDir}, 4'h1);
      bus(1'b1, gpio_port_pkg::DATA_OFFSET, {26'h3FFFFFF, mDat}, 4'h1);
      bus(1'b1, gpio_port_pkg::ODSEL_OFFSET, {26'h3FFFFFF, mOd}, 4'h1);
      bus(1'b1, gpio_port_pkg::STATE_OFFSET, {26'h0, ~mDat}, 4'hF);
      bus(1'b1, gpio_port_pkg::DATA_OFFSET, {26'h0, ~mDat}, 4'hE);
      repeat (3) @(posedge core_clk);
      pins();
      bus(1'b0, gpio_port_pkg::DATA_OFFSET, 32'h0, 4'hF);
      chk(r, {26'h0, mDat});
      bus(1'b0, gpio_port_pkg::ODSEL_OFFSET, 32'h0, 4'hF);
      chk(r, {26'h0, mOd});
      bus(1'b0, gpio_port_pkg::STATE_OFFSET, 32'h0, 4'hF);
      chk(r, {26'h0, (mDir & mDat) | (~mDir & extVal)});
      bus(1'b0, gpio_port_pkg::DIR_OFFSET, 32'h0, 4'hF);
      chk(r, gpio_port_pkg::DIR_READ_VALUE);
    end
    $display("test random done");
    bus(1'b0, 4'h1, 32'h0, 4'hF);
    chk({31'h0, e}, 32'h1);
    // Alternate function drives pin zero although it is an input
    mOd = 6'h00;
    mDir = 6'h00;
    bus(1'b1, gpio_port_pkg::ODSEL_OFFSET, 32'h0, 4'h1);
    bus(1'b1, gpio_port_pkg::DIR_OFFSET, 32'h0, 4'h1);
    altFn[0] <= 3'b111;
    repeat (3) @(posedge core_clk);
    chk({30'h0, pinOe_n[0], pinOut[0]}, 32'h1);
    // Random overrides over random open-drain settings
    repeat (8)
    begin
      mOd = 6'(rnd());
      bus(1'b1, gpio_port_pkg::ODSEL_OFFSET, {26'h0, mOd}, 4'h1);
      altFn <= 18'(rnd());
      repeat (3) @(posedge core_clk);
      pins();
    end
    $display("test alternate done");
    // Overrides cleared first so no stale drive follows the release
    altFn <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    {mDir, mDat, mOd} = 18'h0;
    bus(1'b0, gpio_port_pkg::DATA_OFFSET, 32'h0, 4'hF);
    chk(r, 32'h0);
    bus(1'b0, gpio_port_pkg::ODSEL_OFFSET, 32'h0, 4'hF);
    chk(r, 32'h0);
    pins();
    $display("test reset again done");
    report_and_stop();
  end
endmodule
